// ==== core/dgsc_pkg.sv ====
/*
 * dgsc_pkg: register indices, field positions, reset values and level units
 * for the dac gain swap control block.
 * assumes: levels are carried in 0.5 dB units of attenuation below full scale.
 */
package dgsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] DGSC_IDX_TRIGGER  = 8'h54;
    localparam logic [7:0] DGSC_IDX_DELAY1   = 8'h57;
    localparam logic [7:0] DGSC_IDX_DELAY2   = 8'h58;
    localparam logic [7:0] DGSC_IDX_DELAY3   = 8'h59;
    localparam logic [7:0] DGSC_IDX_LEVELS   = 8'h5A;
    localparam logic [7:0] DGSC_IDX_GAIN     = 8'h5B;
    localparam logic [7:0] DGSC_IDX_STATUS   = 8'h60;

    // field positions
    localparam int DGSC_SIG_LSB   = 4;
    localparam int DGSC_SUBR_BIT  = 6;
    localparam int DGSC_RAMP_BIT  = 5;
    localparam int DGSC_ST_ARMED  = 15;
    localparam int DGSC_ST_PEND   = 14;
    localparam int DGSC_ST_ANA    = 8;

    // reset values
    localparam logic [5:0] DGSC_RST_TRIGGER  = 6'h24;
    localparam logic [7:0] DGSC_RST_DELAY1   = 8'hA3;
    localparam logic [7:0] DGSC_RST_DELAY2   = 8'h31;
    localparam logic [6:0] DGSC_RST_DELAY3   = 7'h11;
    localparam logic [3:0] DGSC_RST_SIGNAL   = 4'h0;
    localparam logic [2:0] DGSC_RST_ANTICLIP = 3'h1;
    localparam logic       DGSC_RST_SUBR     = 1'b1;
    localparam logic       DGSC_RST_RAMP     = 1'b1;
    localparam logic [4:0] DGSC_RST_STEPS    = 5'h14;

    // level units, in 0.5 dB
    localparam logic [7:0] DGSC_HALF_6DB     = 8'h0C;
    localparam logic [7:0] DGSC_HALF_1P5_W   = 8'h03;
    localparam logic [6:0] DGSC_STEP_COARSE  = 7'h03;
    localparam logic [6:0] DGSC_STEP_FINE    = 7'h01;
    localparam logic [6:0] DGSC_STEP_JUMP    = 7'h7F;
    localparam logic [3:0] DGSC_SIG_TOP_CODE = 4'hF;
    localparam logic [7:0] DGSC_SIG_TOP_ATT  = 8'hB4;

    typedef enum logic [0:0] {
        DGSC_ST_IDLE = 1'b0,
        DGSC_ST_WAIT = 1'b1
    } dgsc_state_t;
endpackage : dgsc_pkg

// ==== core/dgsc_core.sv ====
/*
 * dgsc_core: dac gain swap control with its apb register slave. moves gain
 * from the analogue stage into the digital stage while the signal is quiet,
 * ramps it at frame starts and releases the analogue update after a sync delay.
 * assumes: fs16_en, fs8_en, frame_start, voice_mode, fast_rate and sig_atten
 * come from dac path logic on pclk; the fs enables are one-cycle pulses.
 */
`timescale 1ns/1ps
module dgsc_core
    import dgsc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              fs16_en,
    input  wire logic              fs8_en,
    input  wire logic              frame_start,
    input  wire logic              voice_mode,
    input  wire logic              fast_rate,
    input  wire logic [7:0]        sig_atten,
    output logic      [6:0]        dig_gain,
    output logic      [6:0]        ana_gain,
    output logic                   swap_active
);
    // 6 dB per code level decode, shared by start and anti-clip levels
    function automatic logic [7:0] lvl6(input logic [3:0] code);
        lvl6 = 8'(code * DGSC_HALF_6DB);
    endfunction : lvl6

    logic [5:0]  trig_r, trig_nxt;
    logic [7:0]  delay1_r, delay1_nxt;
    logic [7:0]  fast_rate_sync_delay_r, fast_rate_sync_delay_nxt;
    logic [6:0]  voice_sync_delay_field_r, voice_sync_delay_field_nxt;
    logic [3:0]  sig_lvl_r, sig_lvl_nxt;
    logic [2:0]  anticlip_r, anticlip_nxt;
    logic        subr_en_r, subr_en_nxt;
    logic        ramp_en_r, ramp_en_nxt;
    logic [4:0]  steps_r, steps_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;

    logic        armed_r, armed_nxt;
    logic [6:0]  dig_r, dig_nxt;
    logic [6:0]  ana_r, ana_nxt;
    logic [7:0]  cnt_r, cnt_nxt;
    dgsc_state_t st_r, st_nxt;

    logic [7:0]  idx;
    logic        wr_go;
    logic        clip, below, changed, tick;
    logic [6:0]  full, target, step;
    logic [7:0]  dly, sig_thr;

    assign idx = paddr[9:2];
    assign wr_go = psel && penable && pready_r && pwrite;

    // one wait state: pready rises in the second access cycle
    always_comb begin
        trig_nxt = trig_r;
        delay1_nxt = delay1_r;
        fast_rate_sync_delay_nxt = fast_rate_sync_delay_r;
        voice_sync_delay_field_nxt = voice_sync_delay_field_r;
        sig_lvl_nxt = sig_lvl_r;
        anticlip_nxt = anticlip_r;
        subr_en_nxt = subr_en_r;
        ramp_en_nxt = ramp_en_r;
        steps_nxt = steps_r;
        pready_nxt = psel && penable && !pready_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            prdata_nxt = 32'h0000_0000;
            case (idx)
                DGSC_IDX_TRIGGER: prdata_nxt[5:0] = trig_r;
                DGSC_IDX_DELAY1:  prdata_nxt[7:0] = delay1_r;
                DGSC_IDX_DELAY2:  prdata_nxt[7:0] = fast_rate_sync_delay_r;
                DGSC_IDX_DELAY3:  prdata_nxt[6:0] = voice_sync_delay_field_r;
                DGSC_IDX_LEVELS: begin
                    prdata_nxt[DGSC_SIG_LSB+:4] = sig_lvl_r;
                    prdata_nxt[2:0] = anticlip_r;
                end
                DGSC_IDX_GAIN: begin
                    prdata_nxt[DGSC_SUBR_BIT] = subr_en_r;
                    prdata_nxt[DGSC_RAMP_BIT] = ramp_en_r;
                    prdata_nxt[4:0] = steps_r;
                end
                DGSC_IDX_STATUS: begin
                    prdata_nxt[DGSC_ST_ARMED] = armed_r;
                    prdata_nxt[DGSC_ST_PEND] = (st_r == DGSC_ST_WAIT);
                    prdata_nxt[DGSC_ST_ANA+:6] = ana_r[5:0];
                    prdata_nxt[6:0] = dig_r;
                end
                // unmapped index: error, zero data, any write dropped
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (wr_go) begin
            case (idx)
                DGSC_IDX_TRIGGER: trig_nxt = pwdata[5:0];
                DGSC_IDX_DELAY1:  delay1_nxt = pwdata[7:0];
                DGSC_IDX_DELAY2:  fast_rate_sync_delay_nxt = pwdata[7:0];
                DGSC_IDX_DELAY3:  voice_sync_delay_field_nxt = pwdata[6:0];
                DGSC_IDX_LEVELS: begin
                    sig_lvl_nxt = pwdata[DGSC_SIG_LSB+:4];
                    anticlip_nxt = pwdata[2:0];
                end
                DGSC_IDX_GAIN: begin
                    subr_en_nxt = pwdata[DGSC_SUBR_BIT];
                    ramp_en_nxt = pwdata[DGSC_RAMP_BIT];
                    steps_nxt = pwdata[4:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_r <= DGSC_RST_TRIGGER;
            delay1_r <= DGSC_RST_DELAY1;
            fast_rate_sync_delay_r <= DGSC_RST_DELAY2;
            voice_sync_delay_field_r <= DGSC_RST_DELAY3;
            sig_lvl_r <= DGSC_RST_SIGNAL;
            anticlip_r <= DGSC_RST_ANTICLIP;
            subr_en_r <= DGSC_RST_SUBR;
            ramp_en_r <= DGSC_RST_RAMP;
            steps_r <= DGSC_RST_STEPS;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            trig_r <= trig_nxt;
            delay1_r <= delay1_nxt;
            fast_rate_sync_delay_r <= fast_rate_sync_delay_nxt;
            voice_sync_delay_field_r <= voice_sync_delay_field_nxt;
            sig_lvl_r <= sig_lvl_nxt;
            anticlip_r <= anticlip_nxt;
            subr_en_r <= subr_en_nxt;
            ramp_en_r <= ramp_en_nxt;
            steps_r <= steps_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_comb begin
        clip = sig_atten < lvl6({1'b0, anticlip_r});
        sig_thr = (sig_lvl_r == DGSC_SIG_TOP_CODE) ? DGSC_SIG_TOP_ATT : lvl6(sig_lvl_r);
        below = (sig_lvl_r == 4'h0) || (sig_atten > sig_thr);
        armed_nxt = clip ? 1'b0 : (armed_r || below);
        full = 7'({2'b00, steps_r} * DGSC_STEP_COARSE);
        target = (armed_nxt && sig_atten >= 8'({2'b00, trig_r} * DGSC_HALF_1P5_W))
               ? full : 7'h00;
        if (!ramp_en_r)
            step = DGSC_STEP_JUMP;
        else if (subr_en_r)
            step = DGSC_STEP_FINE;
        else
            step = DGSC_STEP_COARSE;
        dig_nxt = dig_r;
        if (clip)
            dig_nxt = 7'h00;
        else if (frame_start) begin
            if (dig_r < target)
                dig_nxt = (target - dig_r > step) ? dig_r + step : target;
            else if (dig_r > target)
                dig_nxt = (dig_r - target > step) ? dig_r - step : target;
        end
        changed = dig_nxt != dig_r;
        // voice mode wins over the fast rate delay
        if (voice_mode) begin
            dly = {1'b0, voice_sync_delay_field_r};
            tick = fs16_en;
        end else begin
            dly = fast_rate ? fast_rate_sync_delay_r : delay1_r;
            tick = fs8_en;
        end
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ana_nxt = ana_r;
        // a new change restarts the delay so analogue never overtakes digital
        if (changed) begin
            st_nxt = DGSC_ST_WAIT;
            cnt_nxt = dly;
        end else begin
            case (st_r)
                DGSC_ST_IDLE: ;
                DGSC_ST_WAIT: begin
                    if (cnt_r == 8'h00) begin
                        ana_nxt = dig_r;
                        st_nxt = DGSC_ST_IDLE;
                    end else if (tick)
                        cnt_nxt = cnt_r - 8'h01;
                end
                default: st_nxt = DGSC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
            dig_r <= 7'h00;
            ana_r <= 7'h00;
            cnt_r <= 8'h00;
            st_r <= DGSC_ST_IDLE;
        end else begin
            armed_r <= armed_nxt;
            dig_r <= dig_nxt;
            ana_r <= ana_nxt;
            cnt_r <= cnt_nxt;
            st_r <= st_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dig_gain = dig_r;
    assign ana_gain = ana_r;
    assign swap_active = armed_r;

    chk_clip_drops_all: assert property (@(posedge pclk) disable iff (!presetn)
        clip |=> (dig_r == 7'h00) && !armed_r)
        else $error("anti-clip did not drop the swap");
    chk_start_level: assert property (@(posedge pclk) disable iff (!presetn)
        (!armed_r && !below) |=> !armed_r)
        else $error("swap armed above the start level");
    chk_jump_no_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && !clip && !ramp_en_r) |=> dig_r == $past(target))
        else $error("unramped step not applied at once");
    chk_coarse_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && !clip && ramp_en_r && !subr_en_r && dig_r + 7'h03 <= target)
        |=> dig_r == $past(dig_r) + 7'h03)
        else $error("coarse ramp step is not 1.5 dB");
    chk_fine_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && !clip && ramp_en_r && subr_en_r && dig_r < target)
        |=> dig_r == $past(dig_r) + 7'h01)
        else $error("fine ramp step is not 0.5 dB");
    chk_steps_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (dig_r <= full && !(wr_go && idx == DGSC_IDX_GAIN)) |=> dig_r <= $past(full))
        else $error("gain exceeds the maximum step count");
    chk_frame_only: assert property (@(posedge pclk) disable iff (!presetn)
        (!frame_start && !clip) |=> $stable(dig_r))
        else $error("digital gain moved outside a frame start");
    chk_delay_load: assert property (@(posedge pclk) disable iff (!presetn)
        changed |=> (st_r == DGSC_ST_WAIT) && (cnt_r == $past(dly)))
        else $error("sync delay not loaded on gain change");
    chk_voice_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == DGSC_ST_WAIT && !changed && voice_mode && fs16_en && cnt_r != 8'h00)
        |=> cnt_r == $past(cnt_r) - 8'h01)
        else $error("voice delay not counted on fs16");
    chk_ana_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == DGSC_ST_WAIT && cnt_r == 8'h00 && !changed)
        |=> (ana_r == $past(dig_r)) && (st_r == DGSC_ST_IDLE))
        else $error("analogue gain did not follow after delay");
    chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
        else $error("apb answer not after one wait state");
    // counts only move on the tick of the selected rate
    chk_fast_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == DGSC_ST_WAIT && !changed && !voice_mode && fs8_en && cnt_r != 8'h00)
        |=> cnt_r == $past(cnt_r) - 8'h01)
        else $error("fs8 delay not counted outside voice mode");
    chk_voice_tick_only: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == DGSC_ST_WAIT && !changed && voice_mode && !fs16_en)
        |=> cnt_r == $past(cnt_r))
        else $error("voice delay moved without an fs16 tick");
    chk_trigger_level: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && !clip && sig_atten < 8'({2'b00, trig_r} * DGSC_HALF_1P5_W))
        |=> dig_r <= $past(dig_r))
        else $error("gain raised above the trigger volume");
    chk_top_code: assert property (@(posedge pclk) disable iff (!presetn)
        (!armed_r && sig_lvl_r == DGSC_SIG_TOP_CODE && sig_atten <= DGSC_SIG_TOP_ATT)
        |=> !armed_r)
        else $error("top start code armed above -90 dB");
    chk_ana_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == DGSC_ST_IDLE && !changed) |=> $stable(ana_r))
        else $error("analogue gain moved with no pending update");
endmodule : dgsc_core

// ==== test/test_dac_gain_swap_control.sv ====
/*
 test_dac_gain_swap_control: directed self-checking bench for dgsc_core.
 assumes: the bench plays the apb master and the dac path pulses on pclk.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_dac_gain_swap_control;
    import dgsc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fs16_en = 1'b0;
    logic        fs8_en = 1'b0;
    logic        frame_start = 1'b0;
    logic        voice_mode = 1'b0;
    logic        fast_rate = 1'b0;
    logic [7:0]  sig_atten = 8'h00;
    logic [6:0]  dig_gain;
    logic [6:0]  ana_gain;
    logic        swap_active;
    logic [31:0] rdat;
    logic        rerr;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;

    dgsc_core dgsc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fs16_en(fs16_en),
        .fs8_en(fs8_en), .frame_start(frame_start), .voice_mode(voice_mode),
        .fast_rate(fast_rate), .sig_atten(sig_atten), .dig_gain(dig_gain),
        .ana_gain(ana_gain), .swap_active(swap_active));

    always #5 pclk = ~pclk;

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // a hang in the pready wait ends here
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    // request held until the edge that sees pready, data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic er);
        apb(1'b0, idx, 32'h0);
        `CHK(rdat, e)
        `CHK(rerr, er)
    endtask : rd

    // k: 0 frame start, 1 fs16 tick, 2 fs8 tick; two idle edges let outputs land
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (k == 0) frame_start <= 1'b1;
            else if (k == 1) fs16_en <= 1'b1;
            else fs8_en <= 1'b1;
            @(posedge pclk);
            frame_start <= 1'b0;
            fs16_en     <= 1'b0;
            fs8_en      <= 1'b0;
        end
        repeat (2) @(posedge pclk);
        #1;
    endtask : pulse

    task automatic atten(input logic [7:0] v, input int n);
        @(posedge pclk);
        sig_atten <= v;
        repeat (n) @(posedge pclk);
        #1;
    endtask : atten

    task automatic t_regs;
        rd(DGSC_IDX_TRIGGER, 32'h24, 1'b0);
        rd(DGSC_IDX_DELAY1, 32'hA3, 1'b0);
        rd(DGSC_IDX_DELAY2, 32'h31, 1'b0);
        rd(DGSC_IDX_DELAY3, 32'h11, 1'b0);
        rd(DGSC_IDX_LEVELS, 32'h01, 1'b0);
        rd(DGSC_IDX_GAIN, 32'h74, 1'b0);
        rd(8'h70, 32'h0, 1'b1);
        wr(DGSC_IDX_DELAY3, 32'hFF);
        rd(DGSC_IDX_DELAY3, 32'h7F, 1'b0);
    endtask : t_regs

    task automatic t_ramp;
        voice_mode <= 1'b1;
        atten(8'hC8, 1);
        wr(DGSC_IDX_LEVELS, 32'h11);
        wr(DGSC_IDX_DELAY3, 32'h03);
        wr(DGSC_IDX_GAIN, 32'h62);
        atten(8'hC8, 2);
        `CHK(swap_active, 1'b1)
        pulse(0, 1);
        `CHK(dig_gain, 7'h01)
        pulse(1, 2);
        `CHK(ana_gain, 7'h00)
        pulse(1, 1);
        `CHK(ana_gain, 7'h01)
        pulse(0, 6);
        `CHK(dig_gain, 7'h06)
    endtask : t_ramp

    task automatic t_modes;
        atten(8'h0C, 2);
        `CHK(swap_active, 1'b1)
        atten(8'h0B, 1);
        `CHK(dig_gain, 7'h00)
        `CHK(swap_active, 1'b0)
        wr(DGSC_IDX_GAIN, 32'h22);
        atten(8'hC8, 2);
        pulse(0, 1);
        `CHK(dig_gain, 7'h03)
        atten(8'h00, 1);
        wr(DGSC_IDX_GAIN, 32'h42);
        atten(8'hC8, 2);
        pulse(0, 1);
        `CHK(dig_gain, 7'h06)
        pulse(1, 3);
        `CHK(ana_gain, 7'h06)
    endtask : t_modes

    task automatic t_delay;
        @(posedge pclk);
        voice_mode <= 1'b0;
        wr(DGSC_IDX_DELAY1, 32'h02);
        wr(DGSC_IDX_DELAY2, 32'h01);
        atten(8'h00, 1);
        pulse(1, 4);
        pulse(2, 1);
        `CHK(ana_gain, 7'h06)
        rd(DGSC_IDX_STATUS, 32'h0000_4600, 1'b0);
        pulse(2, 1);
        `CHK(ana_gain, 7'h00)
        @(posedge pclk);
        fast_rate <= 1'b1;
        atten(8'h64, 2);
        pulse(0, 1);
        `CHK(dig_gain, 7'h00)
        atten(8'hC8, 1);
        pulse(0, 1);
        `CHK(dig_gain, 7'h06)
        pulse(2, 1);
        `CHK(ana_gain, 7'h06)
        rd(DGSC_IDX_STATUS, 32'h0000_8606, 1'b0);
    endtask : t_delay

    task automatic t_levels;
        wr(DGSC_IDX_LEVELS, 32'hF1);
        atten(8'h00, 1);
        atten(8'hB4, 3);
        `CHK(swap_active, 1'b0)
        atten(8'hB5, 3);
        `CHK(swap_active, 1'b1)
    endtask : t_levels

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ramp();
        t_modes();
        t_delay();
        t_levels();
        close_out();
    end
endmodule : test_dac_gain_swap_control
